// [epsr_defines.vh]
// Constants for the enhanced PWM setup controller: own register map,
// device register indices and device field layouts.
// Assumes the device port answers each request with a one-cycle ack.
`ifndef EPSR_DEFINES_VH
`define EPSR_DEFINES_VH

// ----------------------------------------------------------------------
// Own register map (byte offsets)
// ----------------------------------------------------------------------
`define EPSR_OFS_CTRL      8'h00
`define EPSR_OFS_CFG0      8'h04
`define EPSR_OFS_CFG1      8'h08
`define EPSR_OFS_CFG2      8'h0c
`define EPSR_OFS_STATUS    8'h10
`define EPSR_OFS_IRQ_STAT  8'h14
`define EPSR_OFS_IRQ_MASK  8'h18

// CTRL bits
`define EPSR_CTRL_START    0
`define EPSR_CTRL_HALF     1
`define EPSR_CTRL_SHDN     2
`define EPSR_CTRL_RESTART  3
`define EPSR_CTRL_CMP      4
`define EPSR_CTRL_SMALL    5
`define EPSR_CTRL_RST      5'h00

// Reset values of configuration words
`define EPSR_CFG0_RST      26'h0000000
`define EPSR_CFG1_RST      32'h00000000
`define EPSR_CFG2_RST      8'h00
`define EPSR_IRQ_RST       3'h0

// Interrupt bits
`define EPSR_IRQ_DONE      0
`define EPSR_IRQ_FLAG      1
`define EPSR_IRQ_RETRY     2

// ----------------------------------------------------------------------
// Device register indices on the device port
// ----------------------------------------------------------------------
`define EPSR_DEV_DIR       4'h0
`define EPSR_DEV_PERIOD    4'h1
`define EPSR_DEV_PWMCTL    4'h2
`define EPSR_DEV_DUTYLO    4'h3
`define EPSR_DEV_DELAY     4'h4
`define EPSR_DEV_SHDN      4'h5
`define EPSR_DEV_CMPCFG    4'h6
`define EPSR_DEV_FLAGS     4'h7
`define EPSR_DEV_TMRCTL    4'h8
`define EPSR_DEV_ANALOG    4'h9

// Device field positions
`define EPSR_FLAG_MATCH    1
`define EPSR_TMR_RUN       2
`define EPSR_SHDN_ACTIVE   7
`define EPSR_DEL_RESTART   7
`define EPSR_DIR_ALL_IN    8'hff

`endif

// [epsr_host.v]
// Setup controller that drives an enhanced PWM unit through its register
// port, taking orders over a classic Wishbone slave.
// Assumes the device port runs on clk_i and holds ack high for one cycle.
`timescale 1ns/1ps
`include "epsr_defines.vh"

module epsr_host (
  input  wire        clk_i,        // System clock
  input  wire        rst_i,        // Synchronous reset, active high
  input  wire        wb_cyc_i,     // Wishbone cycle
  input  wire        wb_stb_i,     // Wishbone strobe
  input  wire        wb_we_i,      // Wishbone write enable
  input  wire [7:0]  wb_adr_i,     // Wishbone byte address
  input  wire [3:0]  wb_sel_i,     // Wishbone byte selects
  input  wire [31:0] wb_dat_i,     // Wishbone write data
  output wire [31:0] wb_dat_o,     // Wishbone read data
  output wire        wb_ack_o,     // Wishbone acknowledge
  output wire        irq_o,        // Interrupt, level high
  output wire [3:0]  dev_addr_o,   // Device register index
  output wire [7:0]  dev_wdata_o,  // Device write data
  output wire        dev_we_o,     // Device write enable
  output wire        dev_req_o,    // Device request, held until ack
  input  wire [7:0]  dev_rdata_i,  // Device read data
  input  wire        dev_ack_i     // Device acknowledge
);

  // --------------------------------------------------------------------
  // Sequencer states
  // --------------------------------------------------------------------
  localparam [20:0] S_IDLE     = 21'h000001;
  localparam [20:0] S_DIR_IN   = 21'h000002;
  localparam [20:0] S_PERIOD   = 21'h000004;
  localparam [20:0] S_CON      = 21'h000008;
  localparam [20:0] S_DUTY     = 21'h000010;
  localparam [20:0] S_DEL      = 21'h000020;
  localparam [20:0] S_AS       = 21'h000040;
  localparam [20:0] S_CMP      = 21'h000080;
  localparam [20:0] S_ANA      = 21'h000100;
  localparam [20:0] S_RST      = 21'h000200;
  localparam [20:0] S_FLAG_RD  = 21'h000400;
  localparam [20:0] S_FLAG_WR  = 21'h000800;
  localparam [20:0] S_T2_PS    = 21'h001000;
  localparam [20:0] S_T2_ON    = 21'h002000;
  localparam [20:0] S_POLL     = 21'h004000;
  localparam [20:0] S_POLL_CHK = 21'h008000;
  localparam [20:0] S_DIR_OUT  = 21'h010000;
  localparam [20:0] S_ASE_CLR  = 21'h020000;
  localparam [20:0] S_ASE_RD   = 21'h040000;
  localparam [20:0] S_ASE_CHK  = 21'h080000;
  localparam [20:0] S_ACC      = 21'h100000;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function [31:0] epsr_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  sel;
    integer i;
    begin
      epsr_merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          epsr_merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  // --------------------------------------------------------------------
  // Wishbone slave registers
  // --------------------------------------------------------------------
  reg  [4:0]  ctrl_ff;
  reg  [25:0] cfg0_ff;
  reg  [31:0] cfg1_ff;
  reg  [7:0]  cfg2_ff;
  reg  [2:0]  mask_ff;
  reg  [2:0]  irq_ff;
  reg         ack_ff;
  reg  [31:0] rdat_wb_ff;
  reg         start_ff;
  reg  [20:0] state_ff;
  reg  [20:0] ret_ff;
  reg  [3:0]  addr_ff;
  reg  [7:0]  wdata_ff;
  reg         we_ff;
  reg         req_ff;
  reg  [7:0]  rdat_ff;

  wire        acc      = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire        acc_wr   = acc & wb_we_i;
  wire        acc_rd   = acc & ~wb_we_i;
  wire        rd_irq   = acc_rd & (wb_adr_i == `EPSR_OFS_IRQ_STAT);
  wire        busy     = (state_ff != S_IDLE);
  wire [31:0] cfg0_ext = {6'h00, cfg0_ff};
  wire [31:0] cfg0_new = epsr_merge(cfg0_ext, wb_dat_i, wb_sel_i);
  wire [31:0] cfg1_new = epsr_merge(cfg1_ff, wb_dat_i, wb_sel_i);
  wire [31:0] cfg2_new = epsr_merge({24'h000000, cfg2_ff}, wb_dat_i, wb_sel_i);
  wire [31:0] mask_new = epsr_merge({29'h0, mask_ff}, wb_dat_i, wb_sel_i);

  reg  [31:0] nxt_rdat_wb;
  reg         ev_done;
  reg         ev_flag;
  reg         ev_retry;
  wire [2:0]  events   = {ev_retry, ev_flag, ev_done};
  // An event in the cycle of the clearing read survives it
  wire [2:0]  nxt_irq  = (irq_ff & ~(rd_irq ? 3'h7 : 3'h0)) | events;

  always @* begin
    case (wb_adr_i)
      `EPSR_OFS_CTRL:     nxt_rdat_wb = {26'h0, ctrl_ff, 1'b0};
      `EPSR_OFS_CFG0:     nxt_rdat_wb = cfg0_ext;
      `EPSR_OFS_CFG1:     nxt_rdat_wb = cfg1_ff;
      `EPSR_OFS_CFG2:     nxt_rdat_wb = {24'h000000, cfg2_ff};
      `EPSR_OFS_STATUS:   nxt_rdat_wb = {rdat_ff, 2'h0, state_ff, busy};
      `EPSR_OFS_IRQ_STAT: nxt_rdat_wb = {29'h0, irq_ff};
      `EPSR_OFS_IRQ_MASK: nxt_rdat_wb = {29'h0, mask_ff};
      default:            nxt_rdat_wb = 32'h00000000;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff    <= `EPSR_CTRL_RST;
      cfg0_ff    <= `EPSR_CFG0_RST;
      cfg1_ff    <= `EPSR_CFG1_RST;
      cfg2_ff    <= `EPSR_CFG2_RST;
      mask_ff    <= `EPSR_IRQ_RST;
      irq_ff     <= `EPSR_IRQ_RST;
      ack_ff     <= 1'b0;
      rdat_wb_ff <= 32'h00000000;
      start_ff   <= 1'b0;
    end else begin
      ack_ff   <= acc;
      irq_ff   <= nxt_irq;
      start_ff <= 1'b0;
      if (acc_rd) begin
        rdat_wb_ff <= nxt_rdat_wb;
      end
      if (acc_wr) begin
        case (wb_adr_i)
          `EPSR_OFS_CTRL: begin
            if (wb_sel_i[0]) begin
              ctrl_ff  <= wb_dat_i[5:1];
              start_ff <= wb_dat_i[`EPSR_CTRL_START];
            end
          end
          `EPSR_OFS_CFG0:     cfg0_ff <= cfg0_new[25:0];
          `EPSR_OFS_CFG1:     cfg1_ff <= cfg1_new;
          `EPSR_OFS_CFG2:     cfg2_ff <= cfg2_new[7:0];
          `EPSR_OFS_IRQ_MASK: mask_ff <= mask_new[2:0];
          default: begin
          end
        endcase
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_wb_ff;
  assign irq_o    = |(irq_ff & mask_ff);

  // --------------------------------------------------------------------
  // Configuration fields
  // --------------------------------------------------------------------
  wire       half_en  = ctrl_ff[`EPSR_CTRL_HALF - 1];
  wire       shdn_en  = ctrl_ff[`EPSR_CTRL_SHDN - 1];
  wire       rstrt_en = ctrl_ff[`EPSR_CTRL_RESTART - 1];
  wire       cmp_en   = ctrl_ff[`EPSR_CTRL_CMP - 1];
  wire       small_en = ctrl_ff[`EPSR_CTRL_SMALL - 1];

  wire [7:0] period_limit        = cfg0_ff[7:0];
  wire [9:0] duty                = cfg0_ff[17:8];
  wire [1:0] timer_prescale_field = cfg0_ff[19:18];
  wire [1:0] output_config_field = small_en ? 2'h0 : cfg0_ff[21:20];
  wire [3:0] polarity_mode_field = cfg0_ff[25:22];
  wire [6:0] deadband_count      = small_en ? 7'h00 : cfg1_ff[6:0];
  wire [2:0] shutdown_source_field = cfg1_ff[10:8];
  wire [1:0] pair_ac_shutdown_state = cfg1_ff[13:12];
  wire [1:0] pair_bd_shutdown_state = small_en ? 2'h0 : cfg1_ff[15:14];
  wire [3:0] pins_used           = cfg1_ff[19:16];
  wire [7:0] comparator_config   = cfg1_ff[31:24];
  wire [7:0] analog_select       = cfg2_ff;

  // Duty splits: upper eight bits to duty low, lowest two to control
  wire [7:0] duty_low      = duty[9:2];
  wire [1:0] duty_low_bits = duty[1:0];
  wire [7:0] pwm_control   = {output_config_field, duty_low_bits, polarity_mode_field};

  // --------------------------------------------------------------------
  // Setup sequencer
  // --------------------------------------------------------------------
  reg  [20:0] nxt_state;
  reg  [20:0] nxt_ret;
  reg  [3:0]  nxt_addr;
  reg  [7:0]  nxt_wdata;
  reg         nxt_we;
  reg         nxt_req;
  reg  [7:0]  nxt_rdat;
  reg         iss;
  reg  [3:0]  ia;
  reg  [7:0]  iw;
  reg         iwe;
  reg  [20:0] irt;

  always @* begin
    nxt_state = state_ff;
    nxt_ret   = ret_ff;
    nxt_addr  = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_we    = we_ff;
    nxt_req   = req_ff;
    nxt_rdat  = rdat_ff;
    iss       = 1'b0;
    ia        = 4'h0;
    iw        = 8'h00;
    iwe       = 1'b1;
    irt       = S_IDLE;
    ev_done   = 1'b0;
    ev_flag   = 1'b0;
    ev_retry  = 1'b0;
    case (state_ff)
      S_IDLE: begin
        if (start_ff) begin
          nxt_state = S_DIR_IN;
        end
      end
      S_DIR_IN: begin
        iss = 1'b1;
        ia  = `EPSR_DEV_DIR;
        iw  = `EPSR_DIR_ALL_IN;
        irt = S_PERIOD;
      end
      S_PERIOD: begin
        iss = 1'b1;
        ia  = `EPSR_DEV_PERIOD;
        iw  = period_limit;
        irt = S_CON;
      end
      S_CON: begin
        iss = 1'b1;
        ia  = `EPSR_DEV_PWMCTL;
        iw  = pwm_control;
        irt = S_DUTY;
      end
      S_DUTY: begin
        iss = 1'b1;
        ia  = `EPSR_DEV_DUTYLO;
        iw  = duty_low;
        irt = S_DEL;
      end
      S_DEL: begin
        if (half_en && !small_en) begin
          iss = 1'b1;
          ia  = `EPSR_DEV_DELAY;
          iw  = {1'b0, deadband_count};
          irt = S_AS;
        end else begin
          nxt_state = S_AS;
        end
      end
      S_AS: begin
        // Shutdown starts forced so the pins stay safe until a period has run
        if (shdn_en && !small_en) begin
          iss = 1'b1;
          ia  = `EPSR_DEV_SHDN;
          iw  = {1'b1, shutdown_source_field, pair_ac_shutdown_state,
                 pair_bd_shutdown_state};
          irt = S_CMP;
        end else begin
          nxt_state = S_RST;
        end
      end
      S_CMP: begin
        if (cmp_en) begin
          iss = 1'b1;
          ia  = `EPSR_DEV_CMPCFG;
          iw  = comparator_config;
          irt = S_ANA;
        end else begin
          nxt_state = S_RST;
        end
      end
      S_ANA: begin
        iss = 1'b1;
        ia  = `EPSR_DEV_ANALOG;
        iw  = analog_select;
        irt = S_RST;
      end
      S_RST: begin
        if (rstrt_en && !small_en) begin
          iss = 1'b1;
          ia  = `EPSR_DEV_DELAY;
          iw  = {1'b1, half_en ? deadband_count : 7'h00};
          irt = S_FLAG_RD;
        end else begin
          nxt_state = S_FLAG_RD;
        end
      end
      S_FLAG_RD: begin
        iss = 1'b1;
        iwe = 1'b0;
        ia  = `EPSR_DEV_FLAGS;
        irt = S_FLAG_WR;
      end
      S_FLAG_WR: begin
        // Read-modify-write keeps the other peripheral flags untouched
        iss = 1'b1;
        ia  = `EPSR_DEV_FLAGS;
        iw  = rdat_ff & ~(8'h01 << `EPSR_FLAG_MATCH);
        irt = S_T2_PS;
      end
      S_T2_PS: begin
        iss = 1'b1;
        ia  = `EPSR_DEV_TMRCTL;
        iw  = {6'h00, timer_prescale_field};
        irt = S_T2_ON;
      end
      S_T2_ON: begin
        iss = 1'b1;
        ia  = `EPSR_DEV_TMRCTL;
        iw  = {5'h00, 1'b1, timer_prescale_field};
        irt = S_POLL;
      end
      S_POLL: begin
        iss = 1'b1;
        iwe = 1'b0;
        ia  = `EPSR_DEV_FLAGS;
        irt = S_POLL_CHK;
      end
      S_POLL_CHK: begin
        // Flag marks a period match, so a fresh period has just begun
        if (rdat_ff[`EPSR_FLAG_MATCH]) begin
          ev_flag   = 1'b1;
          nxt_state = S_DIR_OUT;
        end else begin
          nxt_state = S_POLL;
        end
      end
      S_DIR_OUT: begin
        iss = 1'b1;
        ia  = `EPSR_DEV_DIR;
        iw  = {4'hf, ~pins_used};
        irt = S_ASE_CLR;
      end
      S_ASE_CLR: begin
        if (shdn_en && !small_en) begin
          iss = 1'b1;
          ia  = `EPSR_DEV_SHDN;
          iw  = {1'b0, shutdown_source_field, pair_ac_shutdown_state,
                 pair_bd_shutdown_state};
          irt = S_ASE_RD;
        end else begin
          ev_done   = 1'b1;
          nxt_state = S_IDLE;
        end
      end
      S_ASE_RD: begin
        iss = 1'b1;
        iwe = 1'b0;
        ia  = `EPSR_DEV_SHDN;
        irt = S_ASE_CHK;
      end
      S_ASE_CHK: begin
        // The clear is ignored while a cause persists; keep retrying
        if (rdat_ff[`EPSR_SHDN_ACTIVE]) begin
          ev_retry  = 1'b1;
          nxt_state = S_ASE_CLR;
        end else begin
          ev_done   = 1'b1;
          nxt_state = S_IDLE;
        end
      end
      S_ACC: begin
        if (dev_ack_i) begin
          nxt_req   = 1'b0;
          nxt_we    = 1'b0;
          nxt_rdat  = dev_rdata_i;
          nxt_state = ret_ff;
        end
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
    if (iss) begin
      nxt_addr  = ia;
      nxt_wdata = iwe ? iw : 8'h00;
      nxt_we    = iwe;
      nxt_req   = 1'b1;
      nxt_ret   = irt;
      nxt_state = S_ACC;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= S_IDLE;
      ret_ff   <= S_IDLE;
      addr_ff  <= 4'h0;
      wdata_ff <= 8'h00;
      we_ff    <= 1'b0;
      req_ff   <= 1'b0;
      rdat_ff  <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      ret_ff   <= nxt_ret;
      addr_ff  <= nxt_addr;
      wdata_ff <= nxt_wdata;
      we_ff    <= nxt_we;
      req_ff   <= nxt_req;
      rdat_ff  <= nxt_rdat;
    end
  end

  assign dev_addr_o  = addr_ff;
  assign dev_wdata_o = wdata_ff;
  assign dev_we_o    = we_ff;
  assign dev_req_o   = req_ff;

endmodule

// [epsr_host_assertions.sv]
// Port-level checker for the PWM setup controller.
// Assumes one clock domain and the synchronous active-high reset rst_i.
`timescale 1ns/1ps
module epsr_host_chk (
  input wire        clk_i,       // Clock
  input wire        rst_i,       // Reset
  input wire        wb_cyc_i,    // Cycle
  input wire        wb_stb_i,    // Strobe
  input wire        wb_we_i,     // Write
  input wire [7:0]  wb_adr_i,    // Address
  input wire [3:0]  wb_sel_i,    // Selects
  input wire [31:0] wb_dat_i,    // Write data
  input wire [31:0] wb_dat_o,    // Read data
  input wire        wb_ack_o,    // Ack
  input wire        irq_o,       // Interrupt
  input wire [3:0]  dev_addr_o,  // Device index
  input wire [7:0]  dev_wdata_o, // Device write data
  input wire        dev_we_o,    // Device write
  input wire        dev_req_o,   // Device request
  input wire [7:0]  dev_rdata_i, // Device read data
  input wire        dev_ack_i    // Device ack
);
  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  wire start_req = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 8'h00
                   && wb_sel_i[0] && wb_dat_i[0];
  wire flag_rd   = dev_ack_i && !dev_we_o && dev_addr_o == 4'h7 && dev_rdata_i[1];
  reg  flag_seen_ff; // Timer flag seen since the last start
  always @(posedge clk_i) begin
    if (rst_i || start_req) flag_seen_ff <= 1'b0;
    else if (flag_rd) flag_seen_ff <= 1'b1;
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  req_hold_a: assert property (dev_req_o && !dev_ack_i |=> dev_req_o
    && $stable({dev_addr_o, dev_we_o, dev_wdata_o})) else $error("device request changed");
  req_drop_a: assert property (dev_req_o && dev_ack_i |=> !dev_req_o)
    else $error("device request held after ack");
  rd_zero_a: assert property (dev_req_o && !dev_we_o |-> dev_wdata_o == 8'h00)
    else $error("write data not zero on read");
  irq_rise_a: assert property ($rose(irq_o) |-> $past(dev_ack_i) || $past(dev_ack_i, 2)
    || $past(wb_stb_i && wb_we_i)) else $error("interrupt without event");
  irq_fall_a: assert property ($fell(irq_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("interrupt dropped without access");
  dir_first_a: assert property (start_req |-> ##[1:8] (dev_req_o && dev_we_o
    && dev_addr_o == 4'h0 && dev_wdata_o == 8'hff)) else $error("pins not made inputs first");
  dir_late_a: assert property (dev_req_o && dev_we_o && dev_addr_o == 4'h0
    && dev_wdata_o != 8'hff |-> flag_seen_ff) else $error("pins enabled before timer flag");
  rst_quiet_a: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !dev_req_o && !irq_o)
    else $error("outputs active after reset");
endmodule

bind epsr_host epsr_host_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
  .dev_addr_o(dev_addr_o), .dev_wdata_o(dev_wdata_o), .dev_we_o(dev_we_o),
  .dev_req_o(dev_req_o), .dev_rdata_i(dev_rdata_i), .dev_ack_i(dev_ack_i));

// [epsr_dev_model.sv]
// Behavioural model of the PWM unit register port.
// Assumes the controller holds a request until the one-cycle ack.
`timescale 1ns/1ps
module epsr_dev_model (
  input  wire       clk_i,   // Clock
  input  wire       rst_i,   // Device reset
  input  wire [3:0] addr_i,  // Register index
  input  wire [7:0] wdata_i, // Write data
  input  wire       we_i,    // Write
  input  wire       req_i,   // Request
  input  wire [2:0] cause_i, // Shutdown causes: pin, cmp2, cmp1
  input  wire [1:0] lat_i,   // Extra answer delay
  output wire [7:0] rdata_o, // Read data
  output wire       ack_o    // Ack pulse
);
  reg [7:0] regs_ff [0:9];
  reg [7:0] rd_ff;
  reg [7:0] tmr_ff;
  reg [1:0] wait_ff;
  reg       ack_ff;
  reg       per_shdn_ff; // Outputs held in shutdown for the current period
  integer   i;
  wire      ev = |(regs_ff[5][6:4] & cause_i);
  assign ack_o   = ack_ff;
  // Bus not answering shows a changed byte, so stale data is caught
  assign rdata_o = ack_ff ? rd_ff : ~rd_ff;
  always @(posedge clk_i) begin
    ack_ff <= 1'b0;
    if (rst_i) begin
      for (i = 0; i < 10; i = i + 1) regs_ff[i] <= 8'h00;
      regs_ff[0] <= 8'hff;
      tmr_ff <= 8'h00;
      wait_ff <= 2'd0;
      rd_ff <= 8'h00;
      per_shdn_ff <= 1'b0;
    end else begin
      if (regs_ff[8][2]) begin
        tmr_ff <= (tmr_ff == regs_ff[1]) ? 8'h00 : tmr_ff + 8'h01;
        if (tmr_ff == regs_ff[1]) regs_ff[7][1] <= 1'b1;
        // Active bit seen at period start holds the outputs off all period
        if (tmr_ff == regs_ff[1]) per_shdn_ff <= regs_ff[5][7];
      end
      if (ev) regs_ff[5][7] <= 1'b1;
      else if (regs_ff[4][7]) regs_ff[5][7] <= 1'b0;
      if (req_i && !ack_ff) begin
        if (wait_ff != lat_i) wait_ff <= wait_ff + 2'd1;
        else begin
          ack_ff <= 1'b1;
          wait_ff <= 2'd0;
          rd_ff <= regs_ff[addr_i];
          if (we_i) regs_ff[addr_i] <= wdata_i;
          if (we_i && addr_i == 4'h5 && ev) regs_ff[5][7] <= 1'b1;
        end
      end
    end
  end
endmodule

// [tb.sv]
// Self-checking bench: Wishbone tasks drive the controller, device model on far side.
// Assumes the controller and the device model share clk_i.
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_tests = n_tests + 1; if ((s) !== (e)) begin fails = fails + 1; \
  $display("wrong value %s exp %0h got %0h", n, e, s); end end
module tb;
  reg        clk_i = 1'b0;
  reg        rst_i = 1'b1;
  reg        dev_rst = 1'b1;
  reg        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  reg [7:0]  adr = 8'h00;
  reg [31:0] dat = 32'h0;
  reg [3:0]  sel = 4'h0;
  reg [2:0]  cause = 3'h0;
  reg [1:0]  lat = 2'd0;
  wire [31:0] rdat;
  wire        ack, irq, dreq, dwe, dack;
  wire [3:0]  daddr;
  wire [7:0]  dwd, drd;
  integer     fails = 0, n_tests = 0, k;
  reg [31:0]  q;
  always #5 clk_i = ~clk_i;
  epsr_host u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .irq_o(irq), .dev_addr_o(daddr), .dev_wdata_o(dwd), .dev_we_o(dwe), .dev_req_o(dreq),
    .dev_rdata_i(drd), .dev_ack_i(dack));
  epsr_dev_model u_dev (.clk_i(clk_i), .rst_i(dev_rst), .addr_i(daddr), .wdata_i(dwd),
    .we_i(dwe), .req_i(dreq), .cause_i(cause), .lat_i(lat), .rdata_o(drd), .ack_o(dack));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task hang;
    begin
      fails = fails + 1;
      end_sim;
    end
  endtask
  task wb(input [7:0] a, input w, input [31:0] d);
    integer i;
    begin
      @(posedge clk_i);
      {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hf};
      i = 0;
      @(posedge clk_i);
      while (ack !== 1'b1 && i < 20) begin
        @(posedge clk_i);
        i = i + 1;
      end
      q = rdat;
      {cyc, stb, we} <= 3'b000;
      if (ack !== 1'b1) hang;
    end
  endtask
  // Poll one bit of an own register until it reads the wanted level
  task poll(input [7:0] a, input integer b, input v);
    integer i;
    begin
      i = 0;
      wb(a, 1'b0, 32'h0);
      while (q[b] !== v && i < 400) begin
        wb(a, 1'b0, 32'h0);
        i = i + 1;
      end
      if (q[b] !== v) hang;
    end
  endtask
  task chk_regs(input [79:0] e);
    for (k = 0; k < 10; k = k + 1) `CHK("device reg", e[8*k+:8], u_dev.regs_ff[k])
  endtask
  task dev_reset;
    begin
      @(posedge clk_i);
      dev_rst <= 1'b1;
      repeat (2) @(posedge clk_i);
      dev_rst <= 1'b0;
      @(posedge clk_i);
      `CHK("dev dir", 8'hff, u_dev.regs_ff[0])
    end
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    dev_rst <= 1'b0;
    @(posedge clk_i);
    chk_regs(80'h00_00_00_00_00_00_00_00_00_ff);
    wb(8'h1c, 1'b1, 32'hffffffff);
    for (k = 0; k < 8; k = k + 1) begin
      if (k != 4) begin
        wb(8'(4 * k), 1'b0, 32'h0);
        `CHK("reset read", 32'h0, q)
      end
    end
    // Half bridge setup with slow device answers
    lat <= 2'd2;
    wb(8'h04, 1'b1, {6'h0, 4'hc, 2'h2, 2'h1, 10'h2b5, 8'h05});
    wb(8'h08, 1'b1, {8'h5a, 4'h0, 4'h3, 2'h2, 2'h1, 1'b0, 3'h3, 1'b0, 7'h15});
    wb(8'h0c, 1'b1, 32'h0f);
    wb(8'h18, 1'b1, 32'h7);
    wb(8'h00, 1'b1, 32'h1f);
    wb(8'h10, 1'b0, 32'h0);
    `CHK("busy", 1'b1, q[0])
    poll(8'h10, 0, 1'b0);
    chk_regs(80'h0f_05_02_5a_36_95_ad_9c_05_fc);
    `CHK("irq", 1'b1, irq)
    wb(8'h14, 1'b0, 32'h0);
    `CHK("irq status", 32'h3, q)
    wb(8'h14, 1'b0, 32'h0);
    `CHK("irq status clear", 32'h0, q)
    `CHK("irq low", 1'b0, irq)
    // Small variant, enhanced fields must stay zero, interrupt masked
    dev_reset;
    lat <= 2'd0;
    wb(8'h18, 1'b1, 32'h0);
    wb(8'h00, 1'b1, 32'h2f);
    poll(8'h10, 0, 1'b0);
    chk_regs(80'h00_05_02_00_00_00_ad_1c_05_fc);
    `CHK("irq masked", 1'b0, irq)
    wb(8'h18, 1'b1, 32'h1);
    `CHK("irq unmasked", 1'b1, irq)
    wb(8'h14, 1'b0, 32'h0);
    `CHK("irq status", 32'h3, q)
    `CHK("irq low", 1'b0, irq)
    // Persistent cause: clearing shutdown-active is ignored and retried
    dev_reset;
    lat <= 2'd1;
    cause <= 3'b001;
    wb(8'h08, 1'b1, {8'h00, 4'h0, 4'h3, 4'h0, 1'b0, 3'h5, 8'h00});
    wb(8'h18, 1'b1, 32'h7);
    wb(8'h00, 1'b1, 32'h05);
    poll(8'h14, 2, 1'b1);
    wb(8'h10, 1'b0, 32'h0);
    `CHK("busy retry", 1'b1, q[0])
    `CHK("active held", 1'b1, u_dev.regs_ff[5][7])
    `CHK("period held", 1'b1, u_dev.per_shdn_ff)
    cause <= 3'b000;
    poll(8'h10, 0, 1'b0);
    `CHK("shdn clear", 8'h50, u_dev.regs_ff[5])
    `CHK("dir", 8'hfc, u_dev.regs_ff[0])
    repeat (8) @(posedge clk_i);
    `CHK("period resumed", 1'b0, u_dev.per_shdn_ff)
    end_sim;
  end
endmodule
